// ### otp_pkg.sv
// constants for the id reads, parameter table and one-time security register commands
// Operation
// - unique id read is opcode 4Bh then four dummy bytes before the id comes out.
// - after the dummy bytes the fixed 64-bit unique id is shifted out on falling clock edges.
// - opcode 9Fh returns maker byte, memory type byte and capacity byte, msb first on falling edges.
// - parameter table read is 5Ah, 24-bit address, eight dummy clocks, output from falling edge 40.
// - the table is 256 bytes, upper address bits are held zero and A7-A0 give the start byte.
// - security erase 44h is refused unless the write permit latch is set.
// - erase address needs A23-16 zero, A15-12 of 1, 2 or 3, A11-8 zero, A7-0 ignored.
// - erase runs only if select rises right after the eighth bit of the last address byte.
// - a valid erase is self-timed with busy high until done, status reads stay available.
// - the write permit latch clears when the erase cycle ends.
// - lock bits guard the three registers, a locked register ignores erase.
// - security program 42h is refused unless the write permit latch is set.
// - program writes one to 256 bytes into locations expected to be erased to FFh.
// - a program to a locked register is ignored.
package otp_pkg;
   localparam logic [7:0] OP_UID = 8'h4B;
   localparam logic [7:0] OP_JEDEC = 8'h9F;
   localparam logic [7:0] OP_PTAB = 8'h5A;
   localparam logic [7:0] OP_ERASE = 8'h44;
   localparam logic [7:0] OP_PROG = 8'h42;
   localparam logic [7:0] OP_WREN = 8'h06;
   localparam logic [7:0] OP_RDSR = 8'h05;
   // bytes clocked in before output starts
   localparam logic [8:0] JID_START = 9'h001;
   localparam logic [8:0] RDSR_START = 9'h001;
   localparam logic [8:0] UID_START = 9'h005;
   localparam logic [8:0] PTAB_START = 9'h005;
   // byte counts on the last edge of an erase / first data byte of a program
   localparam logic [8:0] ERASE_LAST = 9'h003;
   localparam logic [8:0] PROG_DATA = 9'h004;
   localparam logic [3:0] SEL_FIRST = 4'h1;
   localparam logic [3:0] SEL_LAST = 4'h3;
   localparam logic [7:0] ERASED = 8'hFF;
   localparam int OTP_BYTES = 768;
   // register map
   localparam logic [11:0] A_STATUS = 12'h000;
   localparam logic [11:0] A_LOCK = 12'h004;
   localparam logic [11:0] A_OADDR = 12'h008;
   localparam logic [11:0] A_ODATA = 12'h00C;
   localparam int ST_BUSY = 0;
   localparam int ST_WEL = 1;
   localparam int ST_LOCK = 2;
   // timing
   localparam int CLK_PERIOD_PS = 5000;
   localparam int ERASE_TIME_US = 100;
   localparam int PROG_TIME_US = 20;
   localparam int ERASE_CYC_DEF = (ERASE_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int PROG_CYC_DEF = (PROG_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   typedef enum logic [2:0] {
      S_IDLE = 3'b001,
      S_ERASE = 3'b010,
      S_PROG = 3'b100
   } cycle_e;
endpackage

// ### otp_flash.sv
// spi id reads, parameter table and one-time security registers with apb status port
`timescale 1ns/1ps
module otp_flash import otp_pkg::*; #(
   parameter logic [7:0] MFR_ID = 8'hA5, // arbitrary value
   parameter logic [7:0] MEM_TYPE = 8'h60,
   parameter logic [7:0] CAPACITY = 8'h12,
   parameter logic [63:0] UID = 64'h0123456789ABCDEF, // arbitrary value
   parameter int ERASE_CYC = ERASE_CYC_DEF,
   parameter int PROG_CYC = PROG_CYC_DEF
) (
   // system
   input wire logic CLK,
   input wire logic NRST,
   // apb
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // spi link
   input wire logic SCK,
   input wire logic CS_N,
   input wire logic SERIAL_IN,
   output logic SERIAL_OUT,
   output logic SERIAL_OUT_OE
);
   // the walk over 256 bytes must fit inside the timed cycle
   if (ERASE_CYC < 256 || PROG_CYC < 256) begin : g_chk
      $error("erase and program cycle counts must be at least 256");
   end

   function automatic logic [7:0] ptab_byte(input logic [7:0] a);
      case (a)
         8'h00: ptab_byte = 8'h53;
         8'h01: ptab_byte = 8'h46;
         8'h02: ptab_byte = 8'h44;
         8'h03: ptab_byte = 8'h50;
         default: ptab_byte = ERASED;
      endcase
   endfunction

   // ---------------- link side, on SCK ----------------
   typedef struct packed {
      logic [2:0] bitc;
      logic [8:0] bytec;
      logic [7:0] sh;
      logic [7:0] op;
      logic [23:0] addr;
      logic so_bit;
      logic so_en;
   } frame_s;

   typedef struct packed {
      logic tog;
      logic [23:0] addr;
      logic wren_ok;
      logic erase_ok;
      logic prog_ok;
      logic [1:0] busy_sync;
      logic [1:0] wel_sync;
      logic [255:0] bufv;
   } held_s;

   typedef struct packed {
      logic [1:0] cs_sync;
      logic cs_old;
      logic [1:0] tog_sync;
      logic tog_seen;
      logic write_permit_latch;
      logic busy;
      cycle_e cyc;
      logic [1:0] sel;
      logic [31:0] timer;
      logic [8:0] walk;
      logic [2:0] lock;
      logic [9:0] oaddr;
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
   } core_s;

   frame_s fr;
   frame_s next_fr;
   held_s hd;
   held_s next_hd;
   core_s c;
   core_s next_c;
   logic [7:0] pbuf [256];
   logic [7:0] otp [OTP_BYTES];
   logic frame_rst;
   logic byte_done;
   logic buf_we;
   logic [7:0] buf_idx;
   logic [8:0] oidx;
   logic [8:0] ostart;
   logic ovalid;
   logic [7:0] obyte;
   logic [63:0] uid_sh;

   // a frame ends with select, so its state is cleared by select itself
   assign frame_rst = CS_N | ~NRST;

   always_comb begin
      next_fr = fr;
      next_hd = hd;
      buf_we = 1'b0;
      buf_idx = 8'h00;
      byte_done = (fr.bitc == 3'h7);
      next_fr.bitc = fr.bitc + 3'h1;
      next_fr.sh = {fr.sh[6:0], SERIAL_IN};
      next_hd.busy_sync = {hd.busy_sync[0], c.busy};
      next_hd.wel_sync = {hd.wel_sync[0], c.write_permit_latch};
      // marks a new frame for the core side
      if (fr.bitc == 3'h0 && fr.bytec == 9'h000) begin
         next_hd.tog = ~hd.tog;
      end
      if (byte_done && fr.bytec != 9'h1FF) begin
         next_fr.bytec = fr.bytec + 9'h001;
      end
      if (byte_done && fr.bytec == 9'h000) begin
         next_fr.op = next_fr.sh;
      end
      if (byte_done && fr.bytec != 9'h000 && fr.bytec <= ERASE_LAST) begin
         next_fr.addr = {fr.addr[15:0], next_fr.sh};
      end
      // flags only survive if no further edge comes before select rises
      next_hd.wren_ok = byte_done && fr.bytec == 9'h000 && next_fr.sh == OP_WREN;
      next_hd.erase_ok = byte_done && fr.op == OP_ERASE && fr.bytec == ERASE_LAST;
      next_hd.prog_ok = byte_done && fr.op == OP_PROG && fr.bytec >= PROG_DATA;
      if (byte_done && fr.bytec == ERASE_LAST) begin
         next_hd.addr = next_fr.addr;
      end
      // buffer is left alone while the core may still be reading it
      if (byte_done && fr.bytec == 9'h000 && next_fr.sh == OP_PROG && !hd.busy_sync[1]) begin
         next_hd.bufv = '0;
      end
      if (byte_done && fr.op == OP_PROG && fr.bytec >= PROG_DATA && !hd.busy_sync[1]) begin
         buf_we = 1'b1;
         buf_idx = fr.addr[7:0] + 8'(fr.bytec - PROG_DATA);
         next_hd.bufv[buf_idx] = 1'b1;
      end
      // output byte chosen by opcode and bytes clocked so far
      ovalid = 1'b1;
      ostart = JID_START;
      case (next_fr.op)
         OP_JEDEC: ostart = JID_START;
         OP_RDSR: ostart = RDSR_START;
         OP_UID: ostart = UID_START;
         OP_PTAB: ostart = PTAB_START;
         default: ovalid = 1'b0;
      endcase
      if (next_fr.bytec == 9'h000) begin
         ovalid = 1'b0;
      end
      oidx = next_fr.bytec - ostart;
      uid_sh = UID << {oidx[2:0], 3'b000};
      case (next_fr.op)
         OP_JEDEC: begin
            case (oidx)
               9'h000: obyte = MFR_ID;
               9'h001: obyte = MEM_TYPE;
               9'h002: obyte = CAPACITY;
               default: obyte = 8'h00;
            endcase
         end
         OP_RDSR: obyte = {6'h00, hd.wel_sync[1], hd.busy_sync[1]};
         OP_UID: obyte = uid_sh[63:56];
         OP_PTAB: obyte = ptab_byte(next_fr.addr[7:0] + oidx[7:0]);
         default: obyte = 8'h00;
      endcase
      next_fr.so_en = ovalid && next_fr.bytec >= ostart;
      next_fr.so_bit = obyte[3'h7 - next_fr.bitc];
   end

   always_ff @(posedge SCK or posedge frame_rst) begin
      if (frame_rst) begin
         fr <= '0;
      end else begin
         fr <= next_fr;
      end
   end

   always_ff @(posedge SCK or negedge NRST) begin
      if (!NRST) begin
         hd <= '0;
      end else begin
         hd <= next_hd;
      end
   end

   always_ff @(posedge SCK) begin
      if (buf_we) begin
         pbuf[buf_idx] <= next_fr.sh;
      end
   end

   // data changes on the falling edge, released as soon as select rises
   always_ff @(negedge SCK or posedge frame_rst) begin
      if (frame_rst) begin
         SERIAL_OUT <= 1'b0;
         SERIAL_OUT_OE <= 1'b0;
      end else begin
         SERIAL_OUT <= fr.so_bit;
         SERIAL_OUT_OE <= fr.so_en;
      end
   end

   // ---------------- core side, on CLK ----------------
   logic cs_rise;
   logic fresh;
   logic a_ok;
   logic [1:0] asel;
   logic [9:0] widx;

   always_comb begin
      next_c = c;
      next_c.cs_sync = {c.cs_sync[0], CS_N};
      next_c.cs_old = c.cs_sync[1];
      next_c.tog_sync = {c.tog_sync[0], hd.tog};
      cs_rise = c.cs_sync[1] && !c.cs_old;
      fresh = c.tog_sync[1] != c.tog_seen;
      asel = 2'(hd.addr[13:12] - 2'h1);
      a_ok = hd.addr[23:16] == 8'h00 && hd.addr[11:8] == 4'h0
         && hd.addr[15:12] >= SEL_FIRST && hd.addr[15:12] <= SEL_LAST;
      // link flags are stable here: select is high and SCK has stopped
      if (cs_rise) begin
         next_c.tog_seen = c.tog_sync[1];
      end
      if (cs_rise && fresh && !c.busy) begin
         if (hd.wren_ok) begin
            next_c.write_permit_latch = 1'b1;
         end
         if (hd.erase_ok && c.write_permit_latch && a_ok && !c.lock[asel]) begin
            next_c.cyc = S_ERASE;
            next_c.busy = 1'b1;
            next_c.sel = asel;
            next_c.timer = 32'(ERASE_CYC - 1);
            next_c.walk = 9'h000;
         end
         if (hd.prog_ok && c.write_permit_latch && a_ok && !c.lock[asel]) begin
            next_c.cyc = S_PROG;
            next_c.busy = 1'b1;
            next_c.sel = asel;
            next_c.timer = 32'(PROG_CYC - 1);
            next_c.walk = 9'h000;
         end
      end
      case (c.cyc)
         S_IDLE: begin
         end
         S_ERASE, S_PROG: begin
            if (!c.walk[8]) begin
               next_c.walk = c.walk + 9'h001;
            end
            if (c.timer == 32'h0) begin
               next_c.cyc = S_IDLE;
               next_c.busy = 1'b0;
               next_c.write_permit_latch = 1'b0;
            end else begin
               next_c.timer = c.timer - 32'h1;
            end
         end
         default: next_c.cyc = S_IDLE;
      endcase
      // apb: access phase answered one cycle after it starts
      next_c.pready = 1'b0;
      next_c.pslverr = 1'b0;
      if (PSEL && PENABLE && !c.pready) begin
         next_c.pready = 1'b1;
         next_c.prdata = 32'h0;
         case (PADDR)
            A_STATUS: begin
               next_c.prdata[ST_BUSY] = c.busy;
               next_c.prdata[ST_WEL] = c.write_permit_latch;
               next_c.prdata[ST_LOCK +: 3] = c.lock;
            end
            A_LOCK: next_c.prdata[2:0] = c.lock;
            A_OADDR: next_c.prdata[9:0] = c.oaddr;
            A_ODATA: begin
               if (c.oaddr < 10'(OTP_BYTES)) begin
                  next_c.prdata[7:0] = otp[c.oaddr];
               end
            end
            default: next_c.pslverr = 1'b1;
         endcase
      end
      if (PSEL && PENABLE && c.pready && PWRITE) begin
         case (PADDR)
            A_LOCK: next_c.lock = c.lock | PWDATA[2:0];
            A_OADDR: next_c.oaddr = PWDATA[9:0];
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         c <= '{cs_sync: 2'b11, cs_old: 1'b1, cyc: S_IDLE, default: '0};
      end else begin
         c <= next_c;
      end
   end

   assign PRDATA = c.prdata;
   assign PREADY = c.pready;
   assign PSLVERR = c.pslverr;

   // one byte per cycle; programming can only clear bits
   assign widx = {c.sel, c.walk[7:0]};

   always_ff @(posedge CLK) begin
      if (c.cyc == S_ERASE && !c.walk[8]) begin
         otp[widx] <= ERASED;
      end
      if (c.cyc == S_PROG && !c.walk[8] && hd.bufv[c.walk[7:0]]) begin
         otp[widx] <= otp[widx] & pbuf[c.walk[7:0]];
      end
   end
endmodule // otp_flash

// ### otp_flash_checker.sv
// port assertions for the otp flash block
`timescale 1ns/1ps
module otp_flash_checker import otp_pkg::*; (
   // system
   input wire logic CLK,
   input wire logic NRST,
   // apb
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   // spi link
   input wire logic SCK,
   input wire logic CS_N,
   input wire logic SERIAL_IN,
   input wire logic SERIAL_OUT,
   input wire logic SERIAL_OUT_OE
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);
   a_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready too long");
   a_ready_access: assert property (PREADY |-> PSEL && PENABLE) else $error("ready outside access");
   a_ready_late: assert property (PSEL && $rose(PENABLE) |=> PREADY) else $error("ready late");
   a_err_unmapped: assert property (PREADY && PADDR > A_ODATA |-> PSLVERR && PRDATA == 32'h0) else $error("no error");
   a_err_mapped: assert property (PREADY && PADDR <= A_ODATA && PADDR[1:0] == 2'h0 |-> !PSLVERR) else $error("bad error");
   a_status_width: assert property (PREADY && !PWRITE && PADDR == A_STATUS |-> PRDATA[31:5] == 27'h0)
      else $error("status high bits set");
   a_odata_width: assert property (PREADY && !PWRITE && PADDR == A_ODATA |-> PRDATA[31:8] == 24'h0)
      else $error("data high bits set");
   a_oe_deselect: assert property (CS_N |-> !SERIAL_OUT_OE) else $error("output driven while deselected");
   a_out_falling: assert property (!CS_N && SCK && $past(SCK) && $past(!CS_N) |-> $stable(SERIAL_OUT))
      else $error("output moved while clock high");
endmodule // otp_flash_checker
bind otp_flash otp_flash_checker u_chk (.CLK(CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
   .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SCK(SCK),
   .CS_N(CS_N), .SERIAL_IN(SERIAL_IN), .SERIAL_OUT(SERIAL_OUT), .SERIAL_OUT_OE(SERIAL_OUT_OE));

// ### otp_host_model.sv
// host spi controller model, mode 0, msb first
`timescale 1ns/1ps
module otp_host_model (
   // link
   output logic SCK,
   output logic CS_N,
   output logic SERIAL_IN,
   input wire logic SERIAL_OUT,
   input wire logic SERIAL_OUT_OE
);
   initial begin
      SCK = 1'b0;
      CS_N = 1'b1;
      SERIAL_IN = 1'b0;
   end
   // clock idles low between frames; undriven data read as x so it cannot match
   task automatic xfer(input logic [63:0] tx, input int ntx, input int nrx, output logic [63:0] rx);
      rx = 64'h0;
      #3 CS_N = 1'b0;
      for (int i = 0; i < ntx + nrx; i++) begin
         SERIAL_IN = (i < ntx) ? tx[ntx - 1 - i] : ~SERIAL_IN;
         #16 SCK = 1'b1;
         if (i >= ntx)
            rx = {rx[62:0], SERIAL_OUT_OE ? SERIAL_OUT : 1'bx};
         #16 SCK = 1'b0;
      end
      #16 CS_N = 1'b1;
      SERIAL_IN = ~SERIAL_IN;
      #40;
   endtask
endmodule // otp_host_model

// ### otp_flash_tb.sv
// testbench for the otp flash id reads and security registers
`timescale 1ns/1ps
module otp_flash_tb import otp_pkg::*;;
   typedef struct {logic [63:0] tx; int ntx; int nrx; logic [63:0] exp;} row_s;
   localparam logic [7:0] MFR = 8'h5C; // arbitrary value
   localparam logic [63:0] UID_V = 64'h1122334455667788; // arbitrary value
   logic CLK, NRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, SCK, CS_N, SERIAL_IN, SERIAL_OUT, SERIAL_OUT_OE, err;
   logic [11:0] PADDR;
   logic [31:0] PWDATA, PRDATA, rd;
   logic [63:0] rx;
   int n_mismatch = 0;
   int check_count = 0;
   row_s rows [5];
   otp_flash #(.MFR_ID(MFR), .MEM_TYPE(8'h60), .CAPACITY(8'h12), .UID(UID_V), .ERASE_CYC(300), .PROG_CYC(300)) DUT (
      .CLK(CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
      .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SCK(SCK), .CS_N(CS_N), .SERIAL_IN(SERIAL_IN),
      .SERIAL_OUT(SERIAL_OUT), .SERIAL_OUT_OE(SERIAL_OUT_OE));
   otp_host_model host (.SCK(SCK), .CS_N(CS_N), .SERIAL_IN(SERIAL_IN), .SERIAL_OUT(SERIAL_OUT),
      .SERIAL_OUT_OE(SERIAL_OUT_OE));
   initial begin
      CLK = 1'b0;
      forever #2.5 CLK = ~CLK;
   end
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t %s got %0h exp %0h", $time, what, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
      output logic e);
      int n;
      n = 0;
      @(posedge CLK);
      PSEL <= 1'b1;
      PWRITE <= wr;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      do @(posedge CLK); while (PREADY !== 1'b1 && ++n < 50);
      q = PRDATA;
      e = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      if (n >= 50) begin
         n_mismatch++;
         print_verdict();
      end
   endtask
   task automatic st(input logic [31:0] exp, input string what);
      apb(1'b0, A_STATUS, 32'h0, rd, err);
      check(rd, exp, what);
   endtask
   // polls over apb so the spi side stays quiet while busy
   task automatic wait_idle();
      int n;
      n = 0;
      do apb(1'b0, A_STATUS, 32'h0, rd, err); while (rd[ST_BUSY] !== 1'b0 && ++n < 200);
      if (n >= 200) begin
         n_mismatch++;
         print_verdict();
      end
   endtask
   task automatic otp_byte(input logic [9:0] a, input logic [7:0] exp, input string what);
      apb(1'b1, A_OADDR, {22'h0, a}, rd, err);
      apb(1'b0, A_ODATA, 32'h0, rd, err);
      check(rd, {24'h0, exp}, what);
   endtask
   task automatic spi(input logic [63:0] tx, input int ntx);
      host.xfer(tx, ntx, 0, rx);
   endtask
   initial begin
      NRST = 1'b0;
      PSEL = 1'b0;
      PENABLE = 1'b0;
      PWRITE = 1'b0;
      PADDR = 12'h000;
      PWDATA = 32'h0;
      rows[0] = '{{56'h0, OP_JEDEC}, 8, 24, {40'h0, MFR, 8'h60, 8'h12}};
      rows[1] = '{{24'h0, OP_UID, 32'h0}, 40, 64, UID_V};
      rows[2] = '{{24'h0, OP_PTAB, 32'h0}, 40, 32, 64'h53464450};
      rows[3] = '{{24'h0, OP_PTAB, 24'h000002, 8'h0}, 40, 16, 64'h4450};
      rows[4] = '{{24'h0, OP_PTAB, 24'h0000FF, 8'h0}, 40, 16, 64'hFF53};
      repeat (20) @(posedge CLK);
      NRST <= 1'b1;
      repeat (5) @(posedge CLK);
      foreach (rows[i]) begin
         host.xfer(rows[i].tx, rows[i].ntx, rows[i].nrx, rx);
         check(rx, rows[i].exp, "id read");
      end
      $display("test id reads done");
      st(32'h0, "status after reset");
      apb(1'b0, 12'h010, 32'h0, rd, err);
      check({63'h0, err}, 64'h1, "unmapped");
      spi({56'h0, OP_WREN}, 8);
      spi({32'h0, OP_ERASE, 24'h001000}, 32);
      host.xfer({56'h0, OP_RDSR}, 8, 8, rx);
      check(rx & 64'h1, 64'h1, "busy in erase");
      wait_idle();
      st(32'h0, "wel after erase");
      otp_byte(10'h005, 8'hFF, "erased");
      spi({24'h0, OP_PROG, 24'h001005, 8'h3C}, 40);
      st(32'h0, "program without wel");
      otp_byte(10'h005, 8'hFF, "refused program");
      spi({56'h0, OP_WREN}, 8);
      spi({16'h0, OP_PROG, 24'h0010FF, 16'h3CA5}, 48);
      wait_idle();
      st(32'h0, "wel after program");
      otp_byte(10'h0FF, 8'h3C, "program start");
      otp_byte(10'h000, 8'hA5, "program wrap");
      spi({56'h0, OP_WREN}, 8);
      spi({31'h0, OP_ERASE, 24'h001000, 1'b0}, 33);
      st(32'h2, "erase extra bit");
      spi({32'h0, OP_ERASE, 24'h004000}, 32);
      st(32'h2, "erase bad select");
      apb(1'b1, A_LOCK, 32'h1, rd, err);
      spi({32'h0, OP_ERASE, 24'h001000}, 32);
      st(32'h6, "erase locked");
      spi({24'h0, OP_PROG, 24'h001005, 8'h00}, 40);
      st(32'h6, "program locked");
      otp_byte(10'h0FF, 8'h3C, "locked kept");
      otp_byte(10'h005, 8'hFF, "locked not programmed");
      spi({32'h0, OP_ERASE, 24'h003000}, 32);
      wait_idle();
      st(32'h4, "third erased");
      otp_byte(10'h200, 8'hFF, "third register");
      $display("test otp commands done");
      // lock bits are volatile, a mid-run reset must clear them
      @(posedge CLK);
      NRST <= 1'b0;
      repeat (3) @(posedge CLK);
      NRST <= 1'b1;
      st(32'h0, "status after mid-run reset");
      $display("test mid-run reset done");
      print_verdict();
   end
endmodule // otp_flash_tb
